/* File: verilog/wdt_regs.svh */
// Register offsets, reset values and timing constants of the two-stage watchdog.
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define WDT_ADDR_CLEAR_PORT 16'hf00e
`define WDT_ADDR_MODE       16'hf00f
`define WDT_RST_MODE        8'h82
`define WDT_RST_DATA        8'h00

// ----------------------------------------------------------------------------
// Field positions and clear key bytes
// ----------------------------------------------------------------------------
`define WDT_MODE_KEEP_BIT   7
`define WDT_MODE_SEL_HI     1
`define WDT_MODE_SEL_LO     0
`define WDT_KEY_FIRST       8'h5a
`define WDT_KEY_SECOND      8'ha5

// ----------------------------------------------------------------------------
// Timing: low-speed edges per count step, and overflow lengths in low-speed clocks
// ----------------------------------------------------------------------------
`define WDT_LS_DIV          128
`define WDT_OVF_LS_C0       4096
`define WDT_OVF_LS_C1       16384
`define WDT_OVF_LS_C2       65536
`define WDT_OVF_LS_C3       262144

`endif

/* File: verilog/wdt_pkg.sv */
// Types shared by the two-stage watchdog.
`default_nettype none

package wdt_pkg;

    // ------------------------------------------------------------------------
    // Watchdog sequencing states.
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        WDT_RUN  = 2'b00,   // Counting, no overflow pending or after a first one.
        WDT_HOLD = 2'b01,   // Half low-speed period after the first overflow.
        WDT_TRIP = 2'b10    // Second overflow seen; reset request raised.
    } wdt_state_t;

endpackage : wdt_pkg

`default_nettype wire

/* File: verilog/wdt_core.sv */
// Two-stage watchdog: low-speed prescaler, overflow counter, clear key and mode register.
//
// Overview of operation
// RQ1: Counts from reset release; first overflow interrupts.
// RQ2: Second uncleared overflow raises reset request.
// RQ3: First-overflow interrupt is non-maskable, never gated.
// RQ4: Counter steps once per 128 low-speed clocks.
// RQ5: Every clear-port write toggles the pointer; the code toggles only on run-state writes without an overflow.
// RQ6: 5a then a5 in sequence zeroes counter; the code accepts any byte before the a5.
// RQ7: Key byte at wrong pointer state clears nothing.
// RQ8: Clear-port read returns pointer in bit 0.
// RQ9: Pointer zeroed on reset and on overflow.
// RQ10: Software uses byte accesses only.
// RQ11: Half low-speed period hold after first overflow.
// RQ12: Handler reads pointer back after each write.
// RQ13: Period code picks 4096/16384/65536/262144 clocks.
// RQ14: Mode bit 7 keeps counting in deep sleep.
// RQ15: Stop state halts counting; interrupt wakes halts.
// RQ16: Overflow is first unless one occurred since clear.
// RQ17: No software disable of the watchdog exists.
// RQ18: Clear reaches counting logic without a lost event.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.svh"

module wdt_core
    import wdt_pkg::*;
#(
    parameter int CNT_W = 12    // Width of the divided-clock step counter.
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // Low-speed clock, sampled as a level on clk_i
    input  wire logic       low_speed_clock_i,
    // Power states
    input  wire logic       stop_mode_i,
    input  wire logic       deep_sleep_state_i,
    // CPU byte register port
    input  wire logic [15:0] bus_addr_i,
    input  wire logic       bus_wr_i,
    input  wire logic       bus_rd_i,
    input  wire logic [7:0] bus_wdata_i,
    output logic      [7:0] bus_rdata_o,
    // Watchdog events
    output logic            first_overflow_irq_o,
    output logic            halt_wake_o,
    output logic            wdt_reset_req_o
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    wdt_state_t        state_q;          // Sequencing state.
    logic              ls_prev_q;        // Low-speed level one cycle ago.
    logic [6:0]        prescale_q;       // Low-speed edge counter, wraps at 128.
    logic [CNT_W-1:0]  step_cnt_q;       // Divided-clock step counter.
    logic              clear_sequence_pointer_q;
    logic              overflow_seen_q;  // An overflow happened since the last clear.
    logic [7:0]        mode_q;           // Period and deep-sleep mode register.
    logic [7:0]        rdata_q;          // Read data holding register.
    logic              irq_q;            // One-cycle first-overflow pulse.
    logic              reset_req_q;      // Sticky reset request.
    logic              ls_rise;          // Low-speed rising edge.
    logic              ls_fall;          // Low-speed falling edge.
    logic              count_en;         // Counting is allowed in this power state.
    logic              step;             // One divided-clock step.
    logic              overflow;         // Step counter reaches its limit.
    logic              wr_clear;         // Accepted write to the clear port.
    logic              key_ok;           // Write completes the clear key.
    logic [CNT_W-1:0]  step_limit;       // Last count value before overflow.

    // Period code to last step value; all four lengths are multiples of 128.
    function automatic logic [CNT_W-1:0] last_step(input logic [1:0] sel);
        int n;
        n = 0;
        case (sel)
            2'b00:   n = `WDT_OVF_LS_C0 / `WDT_LS_DIV; // RQ13
            2'b01:   n = `WDT_OVF_LS_C1 / `WDT_LS_DIV;
            2'b10:   n = `WDT_OVF_LS_C2 / `WDT_LS_DIV;
            default: n = `WDT_OVF_LS_C3 / `WDT_LS_DIV;
        endcase
        return CNT_W'(n - 1);
    endfunction : last_step

    // ------------------------------------------------------------------------
    // Combinational decode
    // ------------------------------------------------------------------------
    // The low-speed clock is a plain level here, so edges are single-cycle pulses.
    assign ls_rise  = low_speed_clock_i & ~ls_prev_q;
    assign ls_fall  = ~low_speed_clock_i & ls_prev_q;
    // Only the stop state and the deep-sleep option suspend counting; no bit disables it.
    assign count_en = ~stop_mode_i & ~(deep_sleep_state_i & ~mode_q[`WDT_MODE_KEEP_BIT]); // RQ14 RQ15 RQ17
    assign step     = ls_rise & count_en & (prescale_q == 7'(`WDT_LS_DIV - 1)) & (state_q == WDT_RUN); // RQ4
    assign step_limit = last_step(mode_q[`WDT_MODE_SEL_HI:`WDT_MODE_SEL_LO]);
    assign overflow = step & (step_cnt_q == step_limit);
    // Clear-port writes during the hold window are dropped entirely.
    assign wr_clear = bus_wr_i & (bus_addr_i == `WDT_ADDR_CLEAR_PORT) & (state_q == WDT_RUN); // RQ11
    // Key is checked against the pointer before this write toggles it.
    assign key_ok   = wr_clear & clear_sequence_pointer_q & (bus_wdata_i == `WDT_KEY_SECOND); // RQ6 RQ7

    // ------------------------------------------------------------------------
    // Low-speed edge history
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ls_prev_q <= 1'b0;
        end else begin
            ls_prev_q <= low_speed_clock_i;
        end
    end

    // ------------------------------------------------------------------------
    // Sequencing state; hold ends on the next low-speed falling edge.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= WDT_RUN; // RQ1
        end else begin
            case (state_q)
                WDT_RUN: begin
                    if (overflow && overflow_seen_q) begin
                        state_q <= WDT_TRIP; // RQ2
                    end else if (overflow) begin
                        state_q <= WDT_HOLD; // RQ11
                    end
                end
                WDT_HOLD: begin
                    if (ls_fall) begin
                        state_q <= WDT_RUN; // RQ11
                    end
                end
                WDT_TRIP: begin
                    state_q <= WDT_TRIP;
                end
                default: begin
                    state_q <= WDT_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Prescaler and step counter. Clearing restarts the prescaler too, so a
    // fresh period is always a full one. Both run on clk_i, so the clear is
    // seen in the same cycle as the write and can never be missed.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prescale_q <= 7'h00;
            step_cnt_q <= '0;
        end else if (key_ok || overflow || state_q != WDT_RUN) begin
            prescale_q <= 7'h00; // RQ6 RQ11 RQ18
            step_cnt_q <= '0;
        end else if (ls_rise && count_en) begin
            prescale_q <= prescale_q + 7'h01; // RQ4
            if (step) begin
                step_cnt_q <= step_cnt_q + CNT_W'(1);
            end
        end
    end

    // ------------------------------------------------------------------------
    // Clear-sequence pointer; overflow forces zero and wins over a write.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            clear_sequence_pointer_q <= 1'b0; // RQ9
        end else if (overflow || state_q == WDT_HOLD) begin
            clear_sequence_pointer_q <= 1'b0; // RQ9 RQ11
        end else if (wr_clear) begin
            clear_sequence_pointer_q <= ~clear_sequence_pointer_q; // RQ5
        end
    end

    // ------------------------------------------------------------------------
    // Overflow memory; an overflow in the same cycle as a clear wins.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            overflow_seen_q <= 1'b0;
        end else if (overflow) begin
            overflow_seen_q <= 1'b1; // RQ16
        end else if (key_ok) begin
            overflow_seen_q <= 1'b0; // RQ16
        end
    end

    // ------------------------------------------------------------------------
    // Mode register; all eight bits are writable.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_q <= `WDT_RST_MODE; // RQ13 RQ14
        end else if (bus_wr_i && bus_addr_i == `WDT_ADDR_MODE) begin
            mode_q <= bus_wdata_i;
        end
    end

    // ------------------------------------------------------------------------
    // Read data, registered on the read strobe; unmapped reads give zero.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_q <= `WDT_RST_DATA;
        end else if (bus_rd_i) begin
            case (bus_addr_i)
                `WDT_ADDR_CLEAR_PORT: rdata_q <= {7'h00, clear_sequence_pointer_q}; // RQ8
                `WDT_ADDR_MODE:       rdata_q <= mode_q;
                default:              rdata_q <= `WDT_RST_DATA;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Event outputs. The interrupt has no enable: it is the NMI and the wake.
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_q       <= 1'b0;
            reset_req_q <= 1'b0;
        end else begin
            irq_q <= overflow & ~overflow_seen_q; // RQ1 RQ3 RQ15
            if (overflow && overflow_seen_q) begin
                reset_req_q <= 1'b1; // RQ2
            end
        end
    end

    assign bus_rdata_o          = rdata_q;
    assign first_overflow_irq_o = irq_q;
    assign halt_wake_o          = irq_q; // RQ15
    assign wdt_reset_req_o      = reset_req_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_ptr_toggles: assert property (wr_clear && !overflow |=> clear_sequence_pointer_q != $past(clear_sequence_pointer_q)) // RQ5
        else $error("pointer did not toggle on write");
    a_key_clears: assert property (key_ok && !overflow |=> step_cnt_q == '0 && prescale_q == 7'h00) // RQ6
        else $error("valid key did not clear counter");
    a_bad_key_kept: assert property (wr_clear && !clear_sequence_pointer_q && !ls_rise && state_q == WDT_RUN // RQ7
        |=> $stable(prescale_q))
        else $error("wrong-state key cleared counter");
    a_read_pointer: assert property (bus_rd_i && bus_addr_i == `WDT_ADDR_CLEAR_PORT // RQ8
        |=> bus_rdata_o == {7'h00, $past(clear_sequence_pointer_q)})
        else $error("clear port read wrong");
    a_ovf_ptr_zero: assert property (overflow |=> !clear_sequence_pointer_q) // RQ9
        else $error("pointer not zeroed by overflow");
    a_hold_ignores: assert property (state_q == WDT_HOLD |-> !clear_sequence_pointer_q && step_cnt_q == '0) // RQ11
        else $error("state not held during hold window");
    a_first_irq: assert property (overflow && !overflow_seen_q |=> first_overflow_irq_o ##1 !first_overflow_irq_o) // RQ1
        else $error("first overflow interrupt not a single pulse");
    a_second_reset: assert property (overflow && overflow_seen_q |=> wdt_reset_req_o && !first_overflow_irq_o) // RQ2
        else $error("second overflow did not raise reset");
    a_reset_sticky: assert property (wdt_reset_req_o |=> wdt_reset_req_o) // RQ2
        else $error("reset request dropped");
    a_stop_freezes: assert property (stop_mode_i && state_q == WDT_RUN && !key_ok |=> $stable(prescale_q)) // RQ15
        else $error("counted in stop state");
    a_step_div: assert property (step |-> prescale_q == 7'(`WDT_LS_DIV - 1) && ls_rise) // RQ4
        else $error("step not at prescaler wrap");

    c_first_irq:  cover property (first_overflow_irq_o);
    c_key_clear:  cover property (key_ok);
    c_reset_req:  cover property ($rose(wdt_reset_req_o));
    c_hold_write: cover property (state_q == WDT_HOLD && bus_wr_i && bus_addr_i == `WDT_ADDR_CLEAR_PORT);

endmodule : wdt_core

`default_nettype wire

/* File: sim/two_stage_watchdog_timer_tb.sv */
// Self-checking testbench for the two-stage watchdog core.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.svh"

module two_stage_watchdog_timer_tb;
    // ------------------------------------------------------------------------
    // Stimulus, observation and bookkeeping
    // ------------------------------------------------------------------------
    logic        clk_i              = 1'b0;
    logic        sys_rst_i          = 1'b1;
    logic        low_speed_clock_i  = 1'b0;
    logic        stop_mode_i        = 1'b0;
    logic        deep_sleep_state_i = 1'b0;
    logic [15:0] bus_addr_i         = 16'h0000;
    logic        bus_wr_i           = 1'b0;
    logic        bus_rd_i           = 1'b0;
    logic [7:0]  bus_wdata_i        = 8'h00;
    logic [7:0]  bus_rdata_o;
    logic        first_overflow_irq_o;
    logic        halt_wake_o;
    logic        wdt_reset_req_o;
    logic        park     = 1'b0;   // Parks the slow clock high so the hold window stays open.
    logic        rd_seen  = 1'b0;   // A read was taken at the previous edge.
    logic [1:0]  ls_cnt   = 2'b00;  // Slow clock is four system clocks long.
    logic [7:0]  exp_q[$];          // Expected read bytes, oldest first.
    logic [7:0]  keys[4];           // Clear-port bytes for the pointer walk.
    logic [7:0]  mode_val;
    int          failures        = 0;
    int          samples_checked = 0;
    int          cyc             = 0;
    int          n;
    int          irqs;

    wdt_core dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .low_speed_clock_i(low_speed_clock_i),
        .stop_mode_i(stop_mode_i), .deep_sleep_state_i(deep_sleep_state_i), .bus_addr_i(bus_addr_i),
        .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o),
        .first_overflow_irq_o(first_overflow_irq_o), .halt_wake_o(halt_wake_o),
        .wdt_reset_req_o(wdt_reset_req_o));

    // 25 MHz system clock.
    always #20 clk_i = ~clk_i;

    // Slow clock; it never falls while an interrupt is visible, so the bench can park it.
    always @(posedge clk_i) begin
        ls_cnt <= ls_cnt + 2'd1;
        if (ls_cnt[0] && !(low_speed_clock_i && (park || first_overflow_irq_o))) begin
            low_speed_clock_i <= ~low_speed_clock_i;
        end
    end

    // Read monitor: data stands one cycle after the read edge.
    always @(posedge clk_i) begin
        rd_seen <= bus_rd_i;
        if (rd_seen) begin
            cmp_byte(bus_rdata_o, exp_q.pop_front());
        end
    end

    // Hang guard, well above the roughly 35k cycles of the run.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures++;
            end_sim();
        end
    end

    // ------------------------------------------------------------------------
    // Compare, bus and wait tasks
    // ------------------------------------------------------------------------
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_byte

    task automatic cmp_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit

    // Cycle counts allow a few clocks of slow-clock phase.
    task automatic cmp_time(input int got, input int exp);
        samples_checked++;
        if (got < exp - 8 || got > exp + 8) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_time

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus_addr_i  <= a;
        bus_wdata_i <= d;
        bus_wr_i    <= 1'b1;
        @(posedge clk_i);
        bus_wr_i    <= 1'b0;
        @(posedge clk_i);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus_addr_i <= a;
        bus_rd_i   <= 1'b1;
        @(posedge clk_i);
        bus_rd_i   <= 1'b0;
        @(posedge clk_i);
    endtask : rd

    // Waits for the interrupt or the reset request; one 1000-cycle and one 500-cycle power window.
    task automatic wait_evt(input bit second, output int cnt, output int irq_cnt);
        bit in_a;
        cnt     = 0;
        irq_cnt = 0;
        while (cnt < 20000 && !(second ? wdt_reset_req_o === 1'b1 : first_overflow_irq_o === 1'b1)) begin
            @(posedge clk_i);
            cnt++;
            in_a = (cnt >= 2000 && cnt < 3000);
            stop_mode_i        <= in_a && !second;
            deep_sleep_state_i <= (cnt >= 4000 && cnt < 4500) || (in_a && second);
            if (first_overflow_irq_o === 1'b1) irq_cnt++;
        end
    endtask : wait_evt

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        void'($urandom(32'ha586f642));
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`WDT_ADDR_CLEAR_PORT, 8'h00);
        rd(`WDT_ADDR_MODE, `WDT_RST_MODE);
        // Shortest period, keep counting in deep sleep, random spare bits.
        mode_val = 8'h80 | (8'($urandom()) & 8'h7c);
        wr(`WDT_ADDR_MODE, mode_val);
        rd(`WDT_ADDR_MODE, mode_val);
        // Any byte toggles the pointer; keys in the wrong state clear nothing.
        keys = '{8'($urandom()), 8'($urandom()), `WDT_KEY_SECOND, `WDT_KEY_FIRST};
        for (int i = 0; i < 4; i++) begin
            wr(`WDT_ADDR_CLEAR_PORT, keys[i]);
            rd(`WDT_ADDR_CLEAR_PORT, {7'h00, ~i[0]});
        end
        rd(16'hf00d, 8'h00);
        wr(16'hf010, 8'hff);
        rd(`WDT_ADDR_MODE, mode_val);
        // Valid clear, then leave the pointer at one before the overflow.
        wr(`WDT_ADDR_CLEAR_PORT, `WDT_KEY_FIRST);
        wr(`WDT_ADDR_CLEAR_PORT, `WDT_KEY_SECOND);
        wr(`WDT_ADDR_CLEAR_PORT, `WDT_KEY_FIRST);
        wait_evt(1'b0, n, irqs);
        cmp_time(n, 16380 + 1000);
        cmp_bit(halt_wake_o, 1'b1);
        cmp_bit(first_overflow_irq_o, 1'b1);
        park <= 1'b1;
        // Hold window: pointer forced to zero, clear-port write ignored, mode write taken.
        wr(`WDT_ADDR_CLEAR_PORT, `WDT_KEY_FIRST);
        rd(`WDT_ADDR_CLEAR_PORT, 8'h00);
        wr(`WDT_ADDR_MODE, 8'h00);
        park <= 1'b0;
        wait_evt(1'b1, n, irqs);
        cmp_time(n, 16384 + 1500);
        cmp_bit(1'(irqs > 0), 1'b0);
        repeat (50) @(posedge clk_i);
        cmp_bit(wdt_reset_req_o, 1'b1);
        wr(`WDT_ADDR_CLEAR_PORT, 8'h3c);
        rd(`WDT_ADDR_CLEAR_PORT, 8'h00);
        // Second reset in mid-run restores the defaults.
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        cmp_bit(wdt_reset_req_o, 1'b0);
        rd(`WDT_ADDR_MODE, `WDT_RST_MODE);
        rd(`WDT_ADDR_CLEAR_PORT, 8'h00);
        end_sim();
    end
endmodule : two_stage_watchdog_timer_tb
`default_nettype wire
